// [pkg/otp_program_and_lock_defines.vh]
`ifndef OTP_PROGRAM_AND_LOCK_DEFINES_VH
`define OTP_PROGRAM_AND_LOCK_DEFINES_VH

// Command codes
`define CMD_WRITE_ENABLE   8'h06
`define CMD_READ_STATUS    8'h05
`define CMD_READ_FLAGS     8'h70
`define CMD_CLEAR_FLAGS    8'h50
`define CMD_READ_ONETIME   8'h4B
`define CMD_PROG_ONETIME   8'h42

// Status bits
`define SR_BUSY_BIT        0
`define SR_WEL_BIT         1
`define FSR_READY_BIT      7
`define FSR_PROG_FAIL_BIT  4
`define FSR_PROT_BIT       1

// One-time area layout
`define LOCK_INDEX         7'h40
`define LOCK_ADDR          24'h000040
`define LOCK_BIT           0
`define ERASED_BYTE        8'hFF
`define ZERO_BYTE          8'h00

// Frame layout, in bytes
`define OPCODE_BYTE        8'h00
`define LAST_ADDR_BYTE     8'h03
`define FIRST_DATA_BYTE    8'h04
`define MIN_PROG_BYTES     8'h05
`define ONE_BYTE           8'h01
`define BYTE_CNT_MAX       8'hFF
`define LAST_BIT           3'h7

// Timing
`define CLK_PERIOD_NS      10
`define PROG_TIME_NS       200000
`define PROG_TIMEOUT_NS    400000

`endif

// [logic/otp_program_and_lock.v]
// Behaviour
// [R01] Write enable cleared when program ends
// [R02] Status and flags readable while busy
// [R03] Busy bit cleared at program completion
// [R04] Timeout clears write enable, sets fail
// [R05] No chip select rise, no execution
// [R06] Host waits for ready flag read
// [R07] Byte 64 is the permanent lock
// [R08] Lock bit one programmable, zero locked
// [R09] Lock bit never returns to one; here RESET_N_I reloads the whole array with FF, lock bit included
// [R10] Locked: ignore, keep latch, flag bits 1,4
// [R11] Program needs write enable latch set
// [R12] Program starts on chip select rise
// [R13] At most 65 bytes, no wraparound
// [R14] One operation: 64 data plus control
`timescale 1ns/100ps
`include "otp_program_and_lock_defines.vh"

module otp_program_and_lock #(
  parameter PROG_CYCLES    = `PROG_TIME_NS / `CLK_PERIOD_NS,
  parameter TIMEOUT_CYCLES = `PROG_TIMEOUT_NS / `CLK_PERIOD_NS,
  parameter DEPTH          = 65
) (
  // Clock and reset
  input  wire SYS_CLK_I,
  input  wire RESET_N_I,
  // Serial bus from host
  input  wire SPI_CS_N_I,
  input  wire SPI_SCK_I,
  input  wire SPI_DQ0_I,
  // Serial data to host
  output reg  SPI_DQ1_O,
  output reg  SPI_DQ1_OE_O
);

  localparam [31:0] PROG_LAST    = PROG_CYCLES - 1;
  localparam [31:0] TIMEOUT_LAST = TIMEOUT_CYCLES - 1;

  // Pin synchronisers; third stage only for edge detect
  reg        cs_s1;
  reg        cs_s2;
  reg        cs_s3;
  reg        sck_s1;
  reg        sck_s2;
  reg        sck_s3;
  reg        dq_s1;
  reg        dq_s2;

  reg  [7:0] rx;
  reg  [2:0] bit_cnt;
  reg  [7:0] byte_cnt;
  reg  [7:0] cmd;
  reg [23:0] addr;
  reg  [6:0] ptr;
  reg        ptr_ok;
  reg  [7:0] tx;
  reg        out_active;
  reg        wel;
  reg        busy;
  reg        fail;
  reg        prot;
  reg [31:0] tcnt;
  reg  [7:0] otp  [0:DEPTH-1];
  reg  [7:0] pbuf [0:DEPTH-1];
  reg [DEPTH-1:0] pvalid;
  integer    i;

  wire        sck_rise  = sck_s2 & ~sck_s3;
  wire        sck_fall  = ~sck_s2 & sck_s3;
  wire        cs_rise   = cs_s2 & ~cs_s3;
  wire        selected  = ~cs_s2;
  wire  [7:0] rx_next   = {rx[6:0], dq_s2};
  wire [23:0] addr_next = {addr[15:0], rx_next};
  wire        whole     = (bit_cnt == 3'h0);
  wire        unlocked  = otp[`LOCK_INDEX][`LOCK_BIT]; // [R07] [R08]

  reg  [7:0] status;
  reg  [7:0] flags;
  always @* begin
    status                     = `ZERO_BYTE;
    status[`SR_BUSY_BIT]       = busy;
    status[`SR_WEL_BIT]        = wel;
    flags                      = `ZERO_BYTE;
    flags[`FSR_READY_BIT]      = ~busy; // [R06]
    flags[`FSR_PROG_FAIL_BIT]  = fail;
    flags[`FSR_PROT_BIT]       = prot;
  end

  always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
      cs_s3  <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      dq_s1  <= 1'b0;
      dq_s2  <= 1'b0;
    end else begin
      cs_s1  <= SPI_CS_N_I;
      cs_s2  <= cs_s1;
      cs_s3  <= cs_s2;
      sck_s1 <= SPI_SCK_I;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      dq_s1  <= SPI_DQ0_I;
      dq_s2  <= dq_s1;
    end
  end

  // Array reset models the erased, unlocked cell state
  always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rx           <= `ZERO_BYTE;
      bit_cnt      <= 3'h0;
      byte_cnt     <= `OPCODE_BYTE;
      cmd          <= `ZERO_BYTE;
      addr         <= 24'h000000;
      ptr          <= 7'h00;
      ptr_ok       <= 1'b0;
      tx           <= `ZERO_BYTE;
      out_active   <= 1'b0;
      wel          <= 1'b0;
      busy         <= 1'b0;
      fail         <= 1'b0;
      prot         <= 1'b0;
      tcnt         <= 32'h00000000;
      pvalid       <= {DEPTH{1'b0}};
      SPI_DQ1_O    <= 1'b0;
      SPI_DQ1_OE_O <= 1'b0;
      for (i = 0; i < DEPTH; i = i + 1) begin
        otp[i]  <= `ERASED_BYTE;
        pbuf[i] <= `ERASED_BYTE;
      end
    end else begin
      if (!selected) begin
        bit_cnt      <= 3'h0;
        byte_cnt     <= `OPCODE_BYTE;
        out_active   <= 1'b0;
        SPI_DQ1_OE_O <= 1'b0;
      end else if (sck_rise) begin
        rx      <= rx_next;
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == `LAST_BIT) begin
          if (byte_cnt != `BYTE_CNT_MAX)
            byte_cnt <= byte_cnt + `ONE_BYTE;
          if (byte_cnt == `OPCODE_BYTE) begin
            cmd <= rx_next;
            // Status stays readable even while busy
            if (rx_next == `CMD_READ_STATUS) begin // [R02]
              tx         <= status;
              out_active <= 1'b1;
            end else if (rx_next == `CMD_READ_FLAGS) begin // [R02]
              tx         <= flags;
              out_active <= 1'b1;
            end
            // Buffer of a running program must survive
            if (rx_next == `CMD_PROG_ONETIME && !busy)
              pvalid <= {DEPTH{1'b0}};
          end else if (byte_cnt <= `LAST_ADDR_BYTE) begin
            addr <= addr_next;
            if (byte_cnt == `LAST_ADDR_BYTE) begin
              ptr_ok <= (addr_next <= `LOCK_ADDR);
              ptr    <= (addr_next <= `LOCK_ADDR) ? addr_next[6:0] : `LOCK_INDEX;
            end
          end else begin
            if (cmd == `CMD_READ_STATUS) begin
              tx <= status;
            end else if (cmd == `CMD_READ_FLAGS) begin
              tx <= flags;
            end else if (cmd == `CMD_READ_ONETIME && !busy) begin
              // Reads stick at the lock byte instead of wrapping
              tx         <= otp[ptr];
              out_active <= 1'b1;
              if (ptr != `LOCK_INDEX)
                ptr <= ptr + 7'h01;
            end else if (cmd == `CMD_PROG_ONETIME && !busy && ptr_ok) begin
              pbuf[ptr]   <= rx_next; // [R13] [R14]
              pvalid[ptr] <= 1'b1;
              if (ptr == `LOCK_INDEX)
                ptr_ok <= 1'b0; // [R13]
              else
                ptr <= ptr + 7'h01;
            end
          end
        end
      end else if (sck_fall) begin
        SPI_DQ1_O    <= tx[7];
        SPI_DQ1_OE_O <= out_active;
        tx           <= {tx[6:0], 1'b0};
      end

      // Commands act only on a clean chip select rise
      if (cs_rise && whole && !busy) begin // [R05] [R12]
        if (cmd == `CMD_WRITE_ENABLE && byte_cnt == `ONE_BYTE) begin
          wel <= 1'b1;
        end else if (cmd == `CMD_CLEAR_FLAGS && byte_cnt == `ONE_BYTE) begin
          fail <= 1'b0;
          prot <= 1'b0;
        end else if (cmd == `CMD_PROG_ONETIME && byte_cnt >= `MIN_PROG_BYTES && wel) begin // [R11]
          if (!unlocked) begin
            prot <= 1'b1; // [R10]
            fail <= 1'b1; // [R10]
          end else begin
            busy <= 1'b1; // [R12]
            tcnt <= 32'h00000000;
          end
        end
      end

      if (busy) begin
        tcnt <= tcnt + 32'h00000001;
        if (tcnt == TIMEOUT_LAST) begin
          busy <= 1'b0;
          wel  <= 1'b0; // [R04]
          fail <= 1'b1; // [R04]
        end else if (tcnt == PROG_LAST) begin
          busy <= 1'b0; // [R03]
          wel  <= 1'b0; // [R01]
          // Bits only go from one to zero, so a lock holds
          for (i = 0; i < DEPTH; i = i + 1) begin
            if (pvalid[i])
              otp[i] <= otp[i] & pbuf[i]; // [R09] [R14]
          end
        end
      end
    end
  end

endmodule

// [verification/otp_program_and_lock_props.sv]
`timescale 1ns/100ps
module otp_program_and_lock_props (
  // Clock and reset
  input wire SYS_CLK_I,
  input wire RESET_N_I,
  // Serial bus
  input wire SPI_CS_N_I,
  input wire SPI_SCK_I,
  input wire SPI_DQ0_I,
  input wire SPI_DQ1_O,
  input wire SPI_DQ1_OE_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  a_idle_quiet: assert property (SPI_CS_N_I [*5] |-> !SPI_DQ1_OE_O) else $error("oe idle");
  a_data_held: assert property (SPI_SCK_I [*5] |-> $stable(SPI_DQ1_O)) else $error("dq moved");
  a_drive_selected: assert property ($rose(SPI_DQ1_OE_O) |-> !SPI_CS_N_I) else $error("oe cs");
  a_drive_sck_low: assert property ($rose(SPI_DQ1_OE_O) |-> !SPI_SCK_I) else $error("oe sck");
  a_whole_byte: assert property ($rose(SPI_DQ1_OE_O) |-> SPI_DQ1_OE_O [*8]) else $error("oe short");
  a_drive_held: assert property (SPI_DQ1_OE_O && !SPI_CS_N_I |=> SPI_DQ1_OE_O) else $error("oe drop");
  a_release_bound: assert property ($rose(SPI_CS_N_I) |-> ##[1:6] !SPI_DQ1_OE_O) else $error("oe stuck");
  a_release_cause: assert property ($fell(SPI_DQ1_OE_O) |-> $past(SPI_CS_N_I)) else $error("oe fell");
  cover property ($rose(SPI_DQ1_OE_O));
  cover property ($rose(SPI_CS_N_I));
  cover property (SPI_DQ1_OE_O && SPI_DQ1_O);
endmodule
bind otp_program_and_lock otp_program_and_lock_props i_otp_program_and_lock_props (.SYS_CLK_I, .RESET_N_I,
  .SPI_CS_N_I, .SPI_SCK_I, .SPI_DQ0_I, .SPI_DQ1_O, .SPI_DQ1_OE_O);

// [verification/spi_host.sv]
`timescale 1ns/100ps
module spi_host (
  // System clock
  input  wire clk_i,
  // Serial bus, mode 0
  output reg  cs_n_o = 1'h1,
  output reg  sck_o = 1'h0,
  output reg  dq0_o = 1'h0,
  input  wire dq1_i
);
  // Six-clock phases outlast the device's input sync
  task automatic xfer(input logic [63:0] v, input int nb, output logic [7:0] rd);
    cs_n_o = 1'h0;
    for (int i = 0; i < nb; i++) begin
      repeat (6) @(negedge clk_i);
      dq0_o = v[nb - 1 - i];
      repeat (6) @(negedge clk_i);
      sck_o = 1'h1;
      rd = {rd[6:0], dq1_i};
      repeat (6) @(negedge clk_i);
      sck_o = 1'h0;
    end
    repeat (6) @(negedge clk_i);
    cs_n_o = 1'h1;
    dq0_o = ~dq0_o;
    repeat (8) @(negedge clk_i);
  endtask
endmodule

// [verification/test_otp_program_and_lock.sv]
`timescale 1ns/100ps
module test_otp_program_and_lock;
  logic       clk = 1'h0;
  logic       rst_n = 1'h0;
  logic [7:0] rd;
  int         err_total = 0;
  int         total_checks = 0;
  int         n;
  logic       use_tmo = 1'h0;
  wire        cs_n, sck, dq0, dq1, oe;
  wire        cs_n_t, sck_t, dq0_t, dq1_t, oe_t;
  otp_program_and_lock #(.PROG_CYCLES(1000), .TIMEOUT_CYCLES(2000)) i_otp_program_and_lock (.SYS_CLK_I(clk),
    .RESET_N_I(rst_n), .SPI_CS_N_I(cs_n), .SPI_SCK_I(sck), .SPI_DQ0_I(dq0), .SPI_DQ1_O(dq1), .SPI_DQ1_OE_O(oe));
  // Released line reads inverted, so a read outside the answer fails
  spi_host i_spi_host (.clk_i(clk), .cs_n_o(cs_n), .sck_o(sck), .dq0_o(dq0), .dq1_i(oe ? dq1 : ~dq1));
  // Program outlasts the limit here, so every program times out
  otp_program_and_lock #(.PROG_CYCLES(60), .TIMEOUT_CYCLES(40)) i_otp_program_and_lock_tmo (.SYS_CLK_I(clk),
    .RESET_N_I(rst_n), .SPI_CS_N_I(cs_n_t), .SPI_SCK_I(sck_t), .SPI_DQ0_I(dq0_t), .SPI_DQ1_O(dq1_t),
    .SPI_DQ1_OE_O(oe_t));
  spi_host i_spi_host_tmo (.clk_i(clk), .cs_n_o(cs_n_t), .sck_o(sck_t), .dq0_o(dq0_t),
    .dq1_i(oe_t ? dq1_t : ~dq1_t));
  initial begin
    forever #5 clk = ~clk;
  end
  task report_and_stop;
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [63:0] v, input int nb);
    if (use_tmo)
      i_spi_host_tmo.xfer(v, nb, rd);
    else
      i_spi_host.xfer(v, nb, rd);
  endtask
  task rg(input logic [7:0] op, input logic [7:0] e);
    wr({op, 8'h00}, 16);
    check(rd, e);
  endtask
  task otp(input logic [7:0] a, input logic [7:0] e);
    wr({8'h4B, 16'h0000, a, 16'h0000}, 48);
    check(rd, e);
  endtask
  task poll(input logic [7:0] e);
    rd = 8'h00;
    for (n = 0; n < 40 && rd[7] !== 1'h1; n++)
      wr(16'h7000, 16);
    check(rd, e);
    if (rd[7] !== 1'h1)
      report_and_stop;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'h1;
    repeat (3) @(negedge clk);
    rg(8'h05, 8'h00);
    rg(8'h70, 8'h80);
    otp(8'h40, 8'hFF);
    wr({8'h42, 24'h000000, 8'hA5}, 40);
    otp(8'h00, 8'hFF);
    rg(8'h70, 8'h80);
    wr(8'h06, 8);
    rg(8'h05, 8'h02);
    wr({8'h42, 24'h000000, 8'hA5, 4'hA}, 44);
    rg(8'h05, 8'h02);
    rg(8'h70, 8'h80);
    otp(8'h00, 8'hFF);
    wr({8'h42, 24'h00003F, 32'h5A0F3300}, 64);
    rg(8'h05, 8'h03);
    rg(8'h70, 8'h00);
    poll(8'h80);
    rg(8'h05, 8'h00);
    otp(8'h3F, 8'h5A);
    otp(8'h40, 8'h0F);
    otp(8'h00, 8'hFF);
    wr(8'h06, 8);
    wr({8'h42, 24'h000040, 8'hFE}, 40);
    poll(8'h80);
    otp(8'h40, 8'h0E);
    wr(8'h06, 8);
    wr({8'h42, 24'h000040, 8'hFF}, 40);
    rg(8'h70, 8'h92);
    rg(8'h05, 8'h02);
    otp(8'h40, 8'h0E);
    wr(8'h50, 8);
    rg(8'h70, 8'h80);
    use_tmo = 1'h1;
    wr(8'h06, 8);
    wr({8'h42, 24'h000000, 8'h3C}, 40);
    poll(8'h90);
    rg(8'h05, 8'h00);
    otp(8'h00, 8'hFF);
    report_and_stop;
  end
endmodule
